//--- luhp_consts.vh
// Shared constants of the line unit parallel host port
`ifndef LUHP_CONSTS_VH
`define LUHP_CONSTS_VH
`define LUHP_DATA_W       8
`define LUHP_ADDR_W       5
`define LUHP_CTRL_DEPTH   32
`define LUHP_CTRL_RST     8'h00
`define LUHP_SEL_MUX      2'b00
`define LUHP_SEL_NONMUX   2'b01
`define LUHP_SEL_SERIAL   2'b10
`define LUHP_SEL_HW       2'b11
`define LUHP_STS_W        8
`endif

//--- luhp_sync.v
// Three-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module luhp_sync #(
  parameter W = 1
) (
  input  wire         clk_sys, // System clock
  input  wire         rstn,    // Synchronous reset, active low
  input  wire [W-1:0] d,       // Asynchronous input
  output wire [W-1:0] q        // Debounced synchronised output
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  reg [W-1:0] out_q;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      s1_q  <= {W{1'b0}};
      s2_q  <= {W{1'b0}};
      s3_q  <= {W{1'b0}};
      out_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once two late stages agree
      out_q <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & out_q);
    end
  end
  assign q = out_q;
endmodule // luhp_sync

//--- luhp_alert.v
// Status latch and open-drain alert driver
`timescale 1ns/1ps
`include "luhp_consts.vh"
module luhp_alert #(
  parameter W = `LUHP_STS_W
) (
  input  wire         clk_sys,    // System clock
  input  wire         rstn,       // Synchronous reset, active low
  input  wire [W-1:0] cond,       // Synchronised status conditions
  input  wire [W-1:0] enable,     // Per-condition alert enable
  input  wire [W-1:0] clr,        // One-cycle clear of change flags
  output reg  [W-1:0] change_q,   // Sticky change-of-condition flags
  output reg          alert_oe_q  // Drive host_alert_n low when high
);
  reg [W-1:0] prev_q;
  wire [W-1:0] chg;
  assign chg = cond ^ prev_q;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      prev_q     <= {W{1'b0}};
      change_q   <= {W{1'b0}};
      alert_oe_q <= 1'b0;
    end else begin
      prev_q     <= cond;
      // Set wins over clear so no change event is lost
      change_q   <= (change_q & ~clr) | chg;
      alert_oe_q <= |(enable & (cond | change_q));
    end
  end
endmodule // luhp_alert

//--- luhp_host_port.v
// Parallel 8-bit host port with control registers and alert output
`timescale 1ns/1ps
`include "luhp_consts.vh"
// Overview of operation
// - Non-multiplexed mode takes the register address from the five address pins.
// - Multiplexed mode captures the address from the bus lines on the rising latch edge.
// - Accesses happen only while chip select is low; read and write strobes are ignored otherwise, but the address latch still captures.
// - In multiplexed mode the eight bus lines carry address first and then data.
// - In non-multiplexed mode the eight lines carry only data, host on write, device on read.
// - While the reset pin is low, every control register bit is forced to zero.
// - The alert output is pulled low while an enabled condition or change is reported.
// - With the parallel port, timing select high picks strobe-with-direction timing.
// - Timing select high gives the three strobe pins their strobe, address and direction roles.
// - In non-multiplexed strobe-with-direction timing the data strobe is active low.
// - The two select pins pick multiplexed, non-multiplexed, serial or pin control.
module luhp_host_port #(
  parameter DW = `LUHP_DATA_W,
  parameter AW = `LUHP_ADDR_W,
  parameter SW = `LUHP_STS_W
) (
  input  wire          clk_sys,           // System clock, 100 MHz
  input  wire          rstn,              // Synchronous reset, active low
  input  wire          pin_reset_n,       // Hardware reset pin, active low
  input  wire          host_port_sel_lo,  // Interface select bit 0
  input  wire          host_port_sel_hi,  // Interface select bit 1
  input  wire          bus_timing_select, // Strobe style select
  input  wire          chip_select_n,     // Chip select, active low
  input  wire          read_pin,          // Read strobe or data strobe
  input  wire          write_pin,         // Write strobe or direction
  input  wire          address_latch_pulse, // Address latch or strobe
  input  wire [AW-1:0] addr_line,         // addr_line_low..addr_line_high
  input  wire [DW-1:0] bus_line_i,        // bus_line_lsb..msb, input
  output reg  [DW-1:0] bus_line_o,        // Bus lines, output value
  output reg           bus_line_oe,       // Bus lines driven when high
  input  wire [SW-1:0] status_cond,       // Status conditions from the line unit
  output wire [SW-1:0] status_change,     // Sticky change flags
  output wire          host_alert_n_o,    // Alert pin output level
  output wire          host_alert_n_oe,   // Alert pin drive enable
  output wire [DW*`LUHP_CTRL_DEPTH-1:0] ctrl_bits, // All control registers
  output wire          parallel_active    // Parallel port selected
);
  localparam DEPTH = `LUHP_CTRL_DEPTH;
  localparam ST_IDLE = 1'b0;
  localparam ST_ACC  = 1'b1;
  // Status at top address, change flags just below, alert enables below those
  localparam [AW-1:0] STS_ADDR = {AW{1'b1}};
  localparam [AW-1:0] CHG_ADDR = STS_ADDR - 1'b1;
  localparam [AW-1:0] EN_ADDR  = STS_ADDR - 2'd2;

  // Active-low pins pass the synchroniser inverted so its cleared state reads as idle:
  // no false strobe, chip select or pin reset in the cycles after rstn releases
  localparam [DW+AW+7:0] IDLE_MASK = {{(DW+AW){1'b0}}, 8'h8e};
  wire [DW+AW+8-1:0] sync_in;
  wire [DW+AW+8-1:0] sync_raw;
  wire [DW+AW+8-1:0] sync_out;
  assign sync_in = {bus_line_i, addr_line, pin_reset_n, host_port_sel_lo, host_port_sel_hi,
                    bus_timing_select, chip_select_n, read_pin, write_pin,
                    address_latch_pulse} ^ IDLE_MASK;
  luhp_sync #(.W(DW+AW+8)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (sync_in),
    .q       (sync_raw)
  );
  assign sync_out = sync_raw ^ IDLE_MASK;
  wire [DW-1:0] bus_s  = sync_out[DW+AW+7:AW+8];
  wire [AW-1:0] addr_s = sync_out[AW+7:8];
  wire pin_reset_n_n_s = sync_out[7];
  wire [1:0] sel_s = {sync_out[5], sync_out[6]};
  wire bus_timing_select_s = sync_out[4];
  wire cs_n_s = sync_out[3];
  wire rd_s   = sync_out[2];
  wire wr_s   = sync_out[1];
  wire ale_s  = sync_out[0];

  wire is_mux    = (sel_s == `LUHP_SEL_MUX);
  wire is_nonmux = (sel_s == `LUHP_SEL_NONMUX);
  assign parallel_active = is_mux | is_nonmux;

  // Strobe decode per timing style
  wire rd_act = bus_timing_select_s ? (~rd_s & wr_s) : ~rd_s;
  wire wr_act = bus_timing_select_s ? (~rd_s & ~wr_s) : ~wr_s;
  wire sel_ok = parallel_active & ~cs_n_s;

  reg          ale_prev_q;
  reg [AW-1:0] mux_addr_q;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ale_prev_q <= 1'b0;
      mux_addr_q <= {AW{1'b0}};
    end else begin
      ale_prev_q <= ale_s;
      if (is_mux && ale_s && !ale_prev_q)
        mux_addr_q <= bus_s[AW-1:0];
    end
  end
  wire [AW-1:0] acc_addr = is_mux ? mux_addr_q : addr_s;

  reg [DW-1:0] ctrl_q [0:DEPTH-1];
  reg          state_q;
  wire         wr_fire = sel_ok & wr_act & (state_q == ST_IDLE);
  // One write per strobe; edge-held to avoid repeat writes during a long strobe
  always @(posedge clk_sys) begin
    if (!rstn)
      state_q <= ST_IDLE;
    else begin
      case (state_q)
        ST_IDLE: if (sel_ok & wr_act) state_q <= ST_ACC;
        ST_ACC:  if (!(sel_ok & wr_act)) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  wire [SW-1:0] chg_clr = (wr_fire && acc_addr == CHG_ADDR) ? bus_s[SW-1:0] : {SW{1'b0}};
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_ctrl
      localparam integer IDX = gi;
      always @(posedge clk_sys) begin
        if (!rstn || !pin_reset_n_n_s)
          ctrl_q[gi] <= `LUHP_CTRL_RST;
        else if (wr_fire && {{(32-AW){1'b0}}, acc_addr} == IDX)
          ctrl_q[gi] <= bus_s;
      end
      assign ctrl_bits[gi*DW +: DW] = ctrl_q[gi];
    end
  endgenerate

  wire alert_oe;
  luhp_alert #(.W(SW)) u_alert (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .cond       (status_cond),
    .enable     (ctrl_q[EN_ADDR][SW-1:0]),
    .clr        (chg_clr),
    .change_q   (status_change),
    .alert_oe_q (alert_oe)
  );
  assign host_alert_n_o  = 1'b0;
  assign host_alert_n_oe = alert_oe;

  reg [DW-1:0] rd_mux;
  always @* begin
    rd_mux = ctrl_q[acc_addr];
    if (acc_addr == STS_ADDR)
      rd_mux = status_cond;
    else if (acc_addr == CHG_ADDR)
      rd_mux = status_change;
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      bus_line_o  <= {DW{1'b0}};
      bus_line_oe <= 1'b0;
    end else begin
      bus_line_oe <= sel_ok & rd_act;
      if (sel_ok & rd_act)
        bus_line_o <= rd_mux;
    end
  end
endmodule // luhp_host_port

//--- luhp_chk.sv
// Assertion checker for the parallel host port pins
`timescale 1ns/1ps
module luhp_chk #(
  parameter DW = 8,
  parameter SW = 8
) (
  input logic             clk_sys,           // Clock
  input logic             rstn,              // Sync reset
  input logic             pin_reset_n,       // Reset pin
  input logic             host_port_sel_hi,  // Select bit 1
  input logic             bus_timing_select, // Strobe style
  input logic             chip_select_n,     // Chip select
  input logic             read_pin,          // Read strobe
  input logic             write_pin,         // Write or direction
  input logic             bus_line_oe,       // Bus drive
  input logic [SW-1:0]    status_cond,       // Conditions
  input logic [SW-1:0]    status_change,     // Change flags
  input logic             host_alert_n_o,    // Alert level
  input logic             host_alert_n_oe,   // Alert drive
  input logic [DW*32-1:0] ctrl_bits,         // Control registers
  input logic             parallel_active    // Port selected
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Margin of 8 cycles covers the pin synchroniser and agreement stage
  wire [SW-1:0] act = ctrl_bits[DW*29 +: SW] & (status_cond | status_change);
  sequence rd_s;
    !chip_select_n && !read_pin && write_pin && !host_port_sel_hi;
  endsequence
  sequence wr_s;
    !chip_select_n && !read_pin && !write_pin && bus_timing_select && !host_port_sel_hi;
  endsequence
  chk_read_drive: assert property (rd_s [*8] |-> bus_line_oe)
    else $error("bus not driven in read");
  chk_write_dir: assert property (wr_s [*8] |-> !bus_line_oe)
    else $error("bus driven in write");
  chk_idle_rel: assert property (chip_select_n [*8] |-> !bus_line_oe)
    else $error("bus driven while idle");
  chk_cs_ignore: assert property ((chip_select_n && pin_reset_n) [*8] |=> $stable(ctrl_bits))
    else $error("registers changed without chip select");
  chk_pin_reset: assert property (!pin_reset_n [*8] |-> ctrl_bits == '0)
    else $error("control bits not cleared");
  chk_alert_on: assert property ((act != '0) [*8] |-> host_alert_n_oe)
    else $error("alert not raised");
  chk_alert_off: assert property ((act == '0) [*8] |-> !host_alert_n_oe)
    else $error("alert raised without cause");
  chk_alert_od: assert property (host_alert_n_o == 1'b0)
    else $error("alert not open drain");
  chk_port_sel: assert property (host_port_sel_hi [*8] |-> !parallel_active)
    else $error("port active in serial or pin mode");
endmodule // luhp_chk
bind luhp_host_port luhp_chk #(.DW(DW), .SW(SW)) luhp_chk_inst (
  .clk_sys(clk_sys), .rstn(rstn), .pin_reset_n(pin_reset_n),
  .host_port_sel_hi(host_port_sel_hi), .bus_timing_select(bus_timing_select),
  .chip_select_n(chip_select_n), .read_pin(read_pin), .write_pin(write_pin),
  .bus_line_oe(bus_line_oe), .status_cond(status_cond), .status_change(status_change),
  .host_alert_n_o(host_alert_n_o), .host_alert_n_oe(host_alert_n_oe),
  .ctrl_bits(ctrl_bits), .parallel_active(parallel_active));

//--- luhp_host_mdl.sv
// Host processor model for the parallel port
`timescale 1ns/1ps
module luhp_host_mdl (
  input  wire       clk_sys,                    // Clock
  input  wire       host_port_sel_lo,           // Low selects muxed bus
  input  wire       bus_timing_select,          // Strobe style
  input  wire [7:0] bus_line_o,                 // Device data
  input  wire       bus_line_oe,                // Device drive
  output reg        chip_select_n = 1'b1,       // Chip select
  output reg        read_pin = 1'b1,            // Read or data strobe
  output reg        write_pin = 1'b1,           // Write or direction
  output reg        address_latch_pulse = 1'b0, // Latch
  output reg  [4:0] addr_line = 5'h00,          // Address pins
  output wire [7:0] bus_line_i                  // Resolved bus
);
  reg [7:0] drv_q = 8'h00;
  reg       drv_en_q = 1'b0;
  reg [7:0] last_q = 8'h00;
  // A released bus toggles so no stale value can pass for read data
  always @(posedge clk_sys) last_q <= bus_line_i;
  assign bus_line_i = drv_en_q ? drv_q : bus_line_oe ? bus_line_o : ~last_q;
  task acc(input csn, input rd, input [4:0] a, input [7:0] d, output [7:0] q);
    begin
      chip_select_n <= csn;
      if (!host_port_sel_lo) begin
        drv_q <= {3'h0, a};
        drv_en_q <= 1'b1;
        address_latch_pulse <= 1'b1;
        repeat (6) @(posedge clk_sys);
        address_latch_pulse <= 1'b0;
        repeat (6) @(posedge clk_sys);
      end else addr_line <= a;
      drv_q <= d;
      drv_en_q <= !rd;
      read_pin <= !(rd | bus_timing_select);
      write_pin <= rd;
      repeat (8) @(posedge clk_sys);
      q = bus_line_i;
      read_pin <= 1'b1;
      write_pin <= 1'b1;
      chip_select_n <= 1'b1;
      drv_en_q <= 1'b0;
      addr_line <= 5'h00;
      repeat (8) @(posedge clk_sys);
    end
  endtask
endmodule // luhp_host_mdl

//--- testbench.sv
// Self-checking bench for the parallel host port
`timescale 1ns/1ps
module testbench;
  reg          clk_sys = 1'b0, rstn = 1'b0, pin_reset_n = 1'b1;
  reg          sel_lo = 1'b1, sel_hi = 1'b0, bts = 1'b0;
  reg  [7:0]   status_cond = 8'h00, q;
  reg  [14:0]  rows [0:3];
  wire         cs_n, rd_p, wr_p, ale, oe, al_o, al_oe, par;
  wire [4:0]   addr;
  wire [7:0]   bi, bo, chg;
  wire [255:0] ctrl;
  integer      miscompares = 0, checked = 0, i;
  luhp_host_port luhp_host_port_inst (.clk_sys(clk_sys), .rstn(rstn),
    .pin_reset_n(pin_reset_n), .host_port_sel_lo(sel_lo), .host_port_sel_hi(sel_hi),
    .bus_timing_select(bts), .chip_select_n(cs_n), .read_pin(rd_p), .write_pin(wr_p),
    .address_latch_pulse(ale), .addr_line(addr), .bus_line_i(bi), .bus_line_o(bo),
    .bus_line_oe(oe), .status_cond(status_cond), .status_change(chg),
    .host_alert_n_o(al_o), .host_alert_n_oe(al_oe), .ctrl_bits(ctrl), .parallel_active(par));
  luhp_host_mdl luhp_host_mdl_inst (.clk_sys(clk_sys), .host_port_sel_lo(sel_lo),
    .bus_timing_select(bts), .bus_line_o(bo), .bus_line_oe(oe), .chip_select_n(cs_n),
    .read_pin(rd_p), .write_pin(wr_p), .address_latch_pulse(ale), .addr_line(addr),
    .bus_line_i(bi));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      $display("Checks %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    // Row: select bit 0, timing select, address, data
    rows[0] = {2'h0, 5'h00, 8'h5a};
    rows[1] = {2'h1, 5'h1c, 8'ha5};
    rows[2] = {2'h2, 5'h11, 8'hff};
    rows[3] = {2'h3, 5'h07, 8'h81};
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      {sel_lo, bts} <= rows[i][14:13];
      repeat (8) @(posedge clk_sys);
      luhp_host_mdl_inst.acc(1'b0, 1'b0, rows[i][12:8], rows[i][7:0], q);
      chk(ctrl[rows[i][12:8]*8 +: 8], rows[i][7:0]);
      luhp_host_mdl_inst.acc(1'b0, 1'b1, rows[i][12:8], 8'h00, q);
      chk(q, rows[i][7:0]);
      $display("Row test %0d done", i);
    end
    {sel_hi, sel_lo, bts} <= 3'h4;
    repeat (8) @(posedge clk_sys);
    luhp_host_mdl_inst.acc(1'b0, 1'b0, 5'h00, 8'h33, q);
    chk(ctrl[7:0], 8'h5a);
    {sel_hi, sel_lo, bts} <= 3'h2;
    repeat (8) @(posedge clk_sys);
    luhp_host_mdl_inst.acc(1'b1, 1'b0, 5'h00, 8'h33, q);
    chk(ctrl[7:0], 8'h5a);
    $display("Refusal test done");
    luhp_host_mdl_inst.acc(1'b0, 1'b0, 5'h1d, 8'h01, q);
    status_cond <= 8'h01;
    repeat (10) @(posedge clk_sys);
    chk({7'h00, al_oe}, 8'h01);
    luhp_host_mdl_inst.acc(1'b0, 1'b1, 5'h1f, 8'h00, q);
    chk(q, 8'h01);
    status_cond <= 8'h00;
    repeat (10) @(posedge clk_sys);
    chk({7'h00, al_oe}, 8'h01);
    luhp_host_mdl_inst.acc(1'b0, 1'b1, 5'h1e, 8'h00, q);
    chk(q, 8'h01);
    chk(chg, 8'h01);
    luhp_host_mdl_inst.acc(1'b0, 1'b0, 5'h1e, 8'hff, q);
    chk({7'h00, al_oe}, 8'h00);
    chk(chg, 8'h00);
    $display("Alert test done");
    pin_reset_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk({7'h00, |ctrl}, 8'h00);
    $display("Pin reset test done");
    finish_test;
  end
endmodule // testbench
